// File: src/cpf_protect.sv
/*
  Secondary protection fault logic with an AXI4-Lite register slave.
  Assumes comparator levels arrive from the analog protector, the stack
  chain inputs come from the next higher device, and one clock domain.
*/
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
`include "cpf_defs.svh"
module cpf_protect
  import cpf_pkg::*;
#(
  parameter int GUARD_CYCLES = `CPF_GUARD_CYCLES
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Analog protector side
  input  wire cpf_cmp_t    cmp_in,
  output cpf_thr_t         thr_out,
  input  wire logic        sleep_active,
  // Stack chain pins
  input  wire logic        fault_chain_in,
  input  wire logic        alert_chain_in,
  output logic             fault_out,
  output logic             alert_out
);
  // =====================================================================
  // Helpers
  // Enabled cells for a cell count code; unknown codes mean all six
  function automatic logic [5:0] cell_mask(input logic [3:0] f);
    case (f)
      4'h2:    cell_mask = 6'h07;
      4'h8:    cell_mask = 6'h0F;
      4'h4:    cell_mask = 6'h1F;
      default: cell_mask = 6'h3F;
    endcase
  endfunction
  // Mapped register check, shared by both channels
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= `CPF_THRESH);
  endfunction
  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
    end
  endfunction

  // =====================================================================
  // Registers and nets
  cpf_cmp_t    sync1_q, sync2_q;      // Comparator synchroniser stages
  logic [1:0]  chain1_q, chain2_q;    // Chain input synchroniser stages
  logic        sleep_q;               // Previous sleep level
  logic [15:0] guard_q;               // Wake guard countdown
  logic [10:0] pre_q;                 // 50 us grain prescaler
  logic        half_tick;             // One-cycle grain pulse
  logic [3:0]  cells_q;               // cell_count_field
  logic [15:0] dly_q [3];             // Delay settings per source
  logic [31:0] thr_q;                 // Threshold settings word
  logic [5:0]  live [3];              // Qualified live conditions
  logic [5:0]  flags_q [3];           // Latched or tracking flags
  logic [16:0] cnt_q [3];             // Filter timers in grains
  logic [2:0]  clr;                   // Clear strobes per source
  logic [2:0]  src_any;               // Any condition per source
  logic        cmp_en;                // Comparators trusted
  logic        fault_sum, alert_sum;  // Device summaries
  cpf_wr_t     wst_q;                 // Write channel state
  logic [7:0]  awaddr_q;              // Held write address
  logic [31:0] wdata_q;               // Held write data
  logic [3:0]  wstrb_q;               // Held write strobes
  logic        wr_go;                 // Register write this cycle
  logic [7:0]  wa;                    // Effective write address
  logic [31:0] wd;                    // Effective write data
  logic [3:0]  ws;                    // Effective write strobes
  logic        aw_ok, w_ok;           // Channel halves available
  logic        bad_q;                 // Write response error
  logic [31:0] rdata_q;               // Read data
  logic        rbad_q, rvalid_q;      // Read response state
  logic [31:0] rd_mux;                // Selected read word
  logic        fault_q, alert_q;      // Output pin registers

  // All checks share this clock and reset, including the per-source ones
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // =====================================================================
  // Synchronisers: stage one feeds stage two only
  always_ff @(posedge aclk) begin
    sync1_q  <= cmp_in;
    sync2_q  <= sync1_q;
    chain1_q <= {alert_chain_in, fault_chain_in};
    chain2_q <= chain1_q;
  end

  // =====================================================================
  // Wake guard: restart on leaving sleep, masks comparator output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_q <= 1'b0;
      guard_q <= 16'h0000;
    end else begin
      sleep_q <= sleep_active;
      if (sleep_q && !sleep_active) begin
        guard_q <= 16'(GUARD_CYCLES);
      end else if (guard_q != 16'h0000) begin
        guard_q <= guard_q - 16'h0001;
      end
    end
  end
  // Previous sleep level covers the cycle before the guard count loads
  assign cmp_en = !sleep_active && !sleep_q && (guard_q == 16'h0000);

  // Free-running grain; timers align to it, giving the start deglitch
  always_ff @(posedge aclk) begin
    if (!aresetn || half_tick) begin
      pre_q <= 11'h000;
    end else begin
      pre_q <= pre_q + 11'h001;
    end
  end
  assign half_tick = (pre_q == 11'(`CPF_HALF_CYCLES - 1));

  // =====================================================================
  // Live conditions, masked by cell count, wake guard and disabled limits
  assign live[0] = sync2_q.cell_overvoltage & cell_mask(cells_q)
                   & {6{cmp_en}};
  assign live[1] = sync2_q.cell_undervoltage & cell_mask(cells_q)
                   & {6{cmp_en}};
  assign live[2] = {4'h0, sync2_q.over_temperature
                   & {thr_q[`CPF_THR_OT2_LSB +: 4] != 4'h0,
                      thr_q[`CPF_THR_OT1_LSB +: 4] != 4'h0}
                   & {2{cmp_en}}};

  // =====================================================================
  // One filter timer per source; the thermal pair shares one delay
  for (genvar s = 0; s < 3; s++) begin : g_src
    logic [16:0] target;   // Delay in 50 us grains
    logic        dis;      // Delay of zero: no filter, no latch
    logic        hit;      // Timer reaches target this cycle
    logic        held;     // Timer already expired
    logic [5:0]  set;      // Flag set requests
    // One extra grain absorbs the partial first grain, so never early
    assign target     = {dly_q[s], 1'b0} + 17'h1;
    assign dis        = (dly_q[s] == 16'h0000);
    assign src_any[s] = |live[s];
    assign hit        = half_tick && src_any[s] && (cnt_q[s] == target - 17'h1);
    assign held       = (cnt_q[s] == target) && !clr[s];
    assign set        = live[s] & {6{hit || held}};

    // Timer restarts on clear or when the condition goes away
    always_ff @(posedge aclk) begin
      if (!aresetn || clr[s] || !src_any[s] || dis) begin
        cnt_q[s] <= 17'h00000;
      end else if (half_tick && cnt_q[s] != target) begin
        cnt_q[s] <= cnt_q[s] + 17'h00001;
      end
    end

    // Flags latch unless the delay is zero, then they track; a set in the clear cycle wins
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        flags_q[s] <= 6'h00;
      end else if (dis) begin
        flags_q[s] <= live[s];
      end else begin
        flags_q[s] <= (flags_q[s] & ~{6{clr[s]}}) | set;
      end
    end

    a_flag_track: assert property (
      dis && $past(dly_q[s] == 16'h0000) |-> flags_q[s] == $past(live[s]))
      else $error("Unfiltered flag does not track condition");
    a_timer_restart: assert property (
      clr[s] && dly_q[s] != 16'h0000 |=> cnt_q[s] == 17'h0)
      else $error("Timer not restarted by clear");
    a_flag_latch: assert property (
      !dis && $past(!clr[s]) && $past(aresetn) && $stable(dly_q[s]) && $past(!dis)
      |-> (flags_q[s] & $past(flags_q[s])) == $past(flags_q[s]))
      else $error("Latched flag dropped without clear");
  end

  // Only the two thermal bits exist in the third source
  assign fault_sum = |{flags_q[0], flags_q[1]};
  assign alert_sum = |flags_q[2][1:0];

  // =====================================================================
  // Output pins: summaries and chain, independent of the bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_q <= 1'b0;
      alert_q <= 1'b0;
    end else begin
      fault_q <= fault_sum || chain2_q[0];
      alert_q <= alert_sum || chain2_q[1];
    end
  end
  // Active high; the pad driver sinks signalling current while high
  assign fault_out = fault_q;
  assign alert_out = alert_q;
  assign thr_out   = {thr_q[`CPF_THR_OV_LSB +: 6],
                      thr_q[`CPF_THR_UV_LSB +: 6],
                      thr_q[`CPF_THR_OT1_LSB +: 4],
                      thr_q[`CPF_THR_OT2_LSB +: 4]};

  // =====================================================================
  // AXI4-Lite write: address and data accepted in either order
  assign awready = (wst_q == WR_IDLE) || (wst_q == WR_DATA);
  assign wready  = (wst_q == WR_IDLE) || (wst_q == WR_ADDR);
  assign aw_ok   = (awvalid && awready) || (wst_q == WR_ADDR);
  assign w_ok    = (wvalid && wready) || (wst_q == WR_DATA);
  assign wr_go   = aw_ok && w_ok && (wst_q != WR_RESP);
  assign wa      = (wst_q == WR_ADDR) ? awaddr_q : awaddr;
  assign wd      = (wst_q == WR_DATA) ? wdata_q : wdata;
  assign ws      = (wst_q == WR_DATA) ? wstrb_q : wstrb;
  assign bvalid  = (wst_q == WR_RESP);
  assign bresp   = bad_q ? 2'h2 : 2'h0;

  // Write channel progress
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_q <= WR_IDLE;
    end else begin
      case (wst_q)
        WR_IDLE: begin
          if (wr_go) wst_q <= WR_RESP;
          else if (awvalid) wst_q <= WR_ADDR;
          else if (wvalid) wst_q <= WR_DATA;
        end
        WR_ADDR, WR_DATA: begin
          if (wr_go) wst_q <= WR_RESP;
        end
        WR_RESP: begin
          if (bready) wst_q <= WR_IDLE;
        end
        default: wst_q <= WR_IDLE;
      endcase
    end
  end

  // Held halves and response code
  always_ff @(posedge aclk) begin
    if (awvalid && awready) awaddr_q <= awaddr;
    if (wvalid && wready) begin
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end
    if (!aresetn) begin
      bad_q <= 1'b0;
    end else if (wr_go) begin
      bad_q <= !addr_ok(wa);
    end
  end

  // Write one to a status bit clears that source; zero has no effect
  assign clr[0] = wr_go && ws[0] && wa == `CPF_FAULT_STATUS && wd[0];
  assign clr[1] = wr_go && ws[0] && wa == `CPF_FAULT_STATUS && wd[1];
  assign clr[2] = wr_go && ws[0] && wa == `CPF_ALERT_STATUS
                  && (wd[1:0] != 2'h0);

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cells_q <= `CPF_CELLS_RST;
      dly_q   <= '{default: `CPF_DELAY_RST};
      thr_q   <= `CPF_THR_RST;
    end else if (wr_go) begin
      case (wa)
        `CPF_CELL_CFG: if (ws[0]) cells_q <= wd[3:0];
        `CPF_OV_DELAY: dly_q[0] <= 16'(merge({16'h0, dly_q[0]}, wd, ws));
        `CPF_UV_DELAY: dly_q[1] <= 16'(merge({16'h0, dly_q[1]}, wd, ws));
        `CPF_OT_DELAY: dly_q[2] <= 16'(merge({16'h0, dly_q[2]}, wd, ws));
        `CPF_THRESH:   thr_q    <= merge(thr_q, wd, ws) & 32'h00FF_3F3F;
        default: ;
      endcase
    end
  end

  // =====================================================================
  // AXI4-Lite read: one outstanding, answer one cycle after address
  always_comb begin
    case (araddr)
      `CPF_DEV_STATUS:   rd_mux = {28'h0, !cmp_en, chain2_q[0],
                                   alert_sum, fault_sum};
      `CPF_FAULT_STATUS: rd_mux = {30'h0, |flags_q[1], |flags_q[0]};
      `CPF_ALERT_STATUS: rd_mux = {30'h0, flags_q[2][1:0]};
      `CPF_OV_FLAGS:     rd_mux = {26'h0, flags_q[0]};
      `CPF_UV_FLAGS:     rd_mux = {26'h0, flags_q[1]};
      `CPF_CELL_CFG:     rd_mux = {28'h0, cells_q};
      `CPF_OV_DELAY:     rd_mux = {16'h0, dly_q[0]};
      `CPF_UV_DELAY:     rd_mux = {16'h0, dly_q[1]};
      `CPF_OT_DELAY:     rd_mux = {16'h0, dly_q[2]};
      `CPF_THRESH:       rd_mux = thr_q;
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rbad_q   <= 1'b0;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rbad_q   <= !addr_ok(araddr);
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign arready = !rvalid_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rbad_q ? 2'h2 : 2'h0;

  // =====================================================================
  // Checks

  sequence s_wake;
    sleep_q && !sleep_active;
  endsequence
  a_wake_guard: assert property (s_wake |-> !cmp_en [*8])
    else $error("Comparators live too soon after sleep");
  a_fault_pin: assert property (
    fault_out == $past(fault_sum || chain2_q[0]))
    else $error("Fault pin not following summary");
  a_chain_pass: assert property (
    chain2_q[1] |=> alert_out)
    else $error("Alert chain not passed down");
  a_cell_mask: assert property (
    (live[0] & ~cell_mask(cells_q)) == 6'h00)
    else $error("Unused cell seen as overvoltage");
  a_ot_disable: assert property (
    thr_q[`CPF_THR_OT1_LSB +: 4] == 4'h0 |-> !live[2][0])
    else $error("Disabled thermal limit still live");
  a_ov_qualify: assert property (
    $rose(|flags_q[0]) && $past(dly_q[0]) != 16'h0 && $stable(dly_q[0])
    |-> $past(cnt_q[0]) >= {dly_q[0], 1'b0})
    else $error("Overvoltage flag before delay expired");
  a_write_resp: assert property (wr_go |=> bvalid)
    else $error("Write taken without response");
  a_read_resp: assert property (arvalid && arready |=> rvalid)
    else $error("Read taken without response");
endmodule // cpf_protect

// File: include/cpf_defs.svh
/*
  Offsets, field positions, reset values and timing counts for the cell
  protection fault logic. Assumes a 25 MHz register clock.
*/
`ifndef CPF_DEFS_SVH
`define CPF_DEFS_SVH
// =====================================================================
// Register byte offsets
`define CPF_DEV_STATUS   8'h00
`define CPF_FAULT_STATUS 8'h04
`define CPF_ALERT_STATUS 8'h08
`define CPF_OV_FLAGS     8'h0C
`define CPF_UV_FLAGS     8'h10
`define CPF_CELL_CFG     8'h14
`define CPF_OV_DELAY     8'h18
`define CPF_UV_DELAY     8'h1C
`define CPF_OT_DELAY     8'h20
`define CPF_THRESH       8'h24
// =====================================================================
// Field positions in the threshold register
`define CPF_THR_OV_LSB  0
`define CPF_THR_UV_LSB  8
`define CPF_THR_OT1_LSB 16
`define CPF_THR_OT2_LSB 20
// =====================================================================
// Reset values
`define CPF_DELAY_RST  16'h000A
`define CPF_THR_RST    32'h0000_0000
`define CPF_CELLS_RST  4'h0
// =====================================================================
// Timing: clock period, filter step, deglitch grain, wake guard
`define CPF_CLK_PERIOD_NS 40
`define CPF_STEP_US       100
`define CPF_DEGLITCH_US   50
`define CPF_GUARD_US      200
`define CPF_HALF_CYCLES   ((`CPF_DEGLITCH_US * 1000) / `CPF_CLK_PERIOD_NS)
`define CPF_GUARD_CYCLES  ((`CPF_GUARD_US * 1000) / `CPF_CLK_PERIOD_NS)
`endif

// File: include/cpf_pkg.sv
/*
  Types for the cell protection fault logic.
  Assumes six cells and two thermistor comparators per device.
*/
package cpf_pkg;
  // Raw comparator levels from the analog protector
  typedef struct packed {
    logic [5:0] cell_overvoltage;
    logic [5:0] cell_undervoltage;
    logic [1:0] over_temperature;
  } cpf_cmp_t;
  // Threshold settings handed to the analog comparators
  typedef struct packed {
    logic [5:0] overvoltage_threshold_setting;
    logic [5:0] undervoltage_threshold_setting;
    logic [3:0] thermal_limit_one;
    logic [3:0] thermal_limit_two;
  } cpf_thr_t;
  // Write channel progress
  typedef enum logic [1:0] {WR_IDLE, WR_ADDR, WR_DATA, WR_RESP} cpf_wr_t;
endpackage

// File: verif/cpf_far_model.sv
/*
  Far-side model: the analog comparators and the next higher device.
  Assumes the bench sets the wanted conditions right after a clock edge.
*/
`timescale 1ns/100ps
module cpf_far_model
  import cpf_pkg::*;
#(
  parameter int LAG = 3  // Comparator settling, in clocks
) (
  // Clock
  input  wire logic     aclk,
  // Wanted conditions
  input  wire cpf_cmp_t cond,
  input  wire logic     hi_fault,
  input  wire logic     hi_alert,
  // Protector side
  output cpf_cmp_t      cmp_in,
  output logic          fault_chain_in,
  output logic          alert_chain_in
);
  cpf_cmp_t pipe_q [LAG];  // Settling line, slow analog edges
  // ===================================================================
  // Comparators: each source has its own level, seen LAG clocks late
  always_ff @(posedge aclk) begin
    pipe_q[0] <= cond;
    for (int i = 1; i < LAG; i++) begin
      pipe_q[i] <= pipe_q[i-1];
    end
  end
  assign cmp_in         = pipe_q[LAG-1];
  // Chain pins active high, idle low
  assign fault_chain_in = hi_fault;
  assign alert_chain_in = hi_alert;
endmodule // cpf_far_model

// File: verif/test_cell_protection_fault_logic.sv
/*
  Self-checking bench for the cell protection fault logic.
  Assumes the far-side model and a 25 MHz clock.
*/
`timescale 1ns/100ps
`include "cpf_defs.svh"
module test_cell_protection_fault_logic;
  import cpf_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, sleep_active;
  logic        fault_chain_in, alert_chain_in, fault_out, alert_out, hi_fault, hi_alert;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  cpf_cmp_t    cond, cmp_in;
  cpf_thr_t    thr_out;
  int          checks, n_mismatch;
  // ===================================================================
  // Design and far side
  cpf_protect #(.GUARD_CYCLES(20)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .cmp_in(cmp_in), .thr_out(thr_out),
    .sleep_active(sleep_active), .fault_chain_in(fault_chain_in),
    .alert_chain_in(alert_chain_in), .fault_out(fault_out), .alert_out(alert_out));
  cpf_far_model #(.LAG(3)) far_u (.aclk(aclk), .cond(cond), .hi_fault(hi_fault),
    .hi_alert(hi_alert),
    .cmp_in(cmp_in), .fault_chain_in(fault_chain_in), .alert_chain_in(alert_chain_in));
  // ===================================================================
  // Clock, 40 ns period
  always #20 aclk = ~aclk;
  // ===================================================================
  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Pins are read mid-cycle, where they have settled; returns on a rising edge
  task automatic pin(input logic ef, input logic ea);
    @(negedge aclk);
    chk({30'h0, fault_out, alert_out}, {30'h0, ef, ea});
    @(posedge aclk);
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ===================================================================
  // Bus master; readies are looked at mid-cycle, stable until the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hit;
    logic w_hit;
    logic aw_done = 1'b0;
    logic w_done = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge aclk);
      aw_hit = awvalid & awready;
      w_hit  = wvalid & wready;
      @(posedge aclk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      aw_done |= aw_hit;
      w_done  |= w_hit;
    end
    bready <= 1'b1;
    do @(negedge aclk); while (bvalid !== 1'b1);
    chk({30'h0, bresp}, 32'h0);
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  // Read one word and compare data and response
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // ===================================================================
  // Watchdog: the tests need about 12000 clocks
  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    close_out();
  end
  // ===================================================================
  // Main sequence
  initial begin
    aclk = 1'b0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; cond = '0; hi_fault = 1'b0; hi_alert = 1'b0; sleep_active = 1'b0;
    checks = 0; n_mismatch = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, an unmapped place, threshold fields
    rc(`CPF_OV_DELAY, 32'h0000_000A);
    rc(`CPF_THRESH, 32'h0);
    rc(`CPF_DEV_STATUS, 32'h0);
    rc(8'h30, 32'h0, 2'h2);
    wr(`CPF_THRESH, 32'hFF11_C305);
    pin(1'b0, 1'b0);
    chk({12'h0, thr_out}, 32'h0001_4311);
    rc(`CPF_THRESH, 32'h0011_0305);
    // Filter off: flag follows the live condition
    wr(`CPF_OV_DELAY, 32'h0);
    cond.cell_overvoltage <= 6'h01;
    repeat (8) @(posedge aclk);
    rc(`CPF_OV_FLAGS, 32'h1);
    pin(1'b1, 1'b0);
    cond <= '0;
    repeat (8) @(posedge aclk);
    rc(`CPF_OV_FLAGS, 32'h0);
    // Four cells: cell five ignored, cell four seen
    wr(`CPF_CELL_CFG, 32'h8);
    cond.cell_overvoltage <= 6'h10;
    repeat (8) @(posedge aclk);
    rc(`CPF_OV_FLAGS, 32'h0);
    cond.cell_overvoltage <= 6'h08;
    repeat (8) @(posedge aclk);
    rc(`CPF_OV_FLAGS, 32'h8);
    // Sleep and the wake guard mask comparators
    sleep_active <= 1'b1;
    cond.cell_overvoltage <= 6'h01;
    repeat (8) @(posedge aclk);
    rc(`CPF_DEV_STATUS, 32'h8);
    sleep_active <= 1'b0;
    rc(`CPF_OV_FLAGS, 32'h0);
    repeat (30) @(posedge aclk);
    rc(`CPF_OV_FLAGS, 32'h1);
    cond <= '0;
    // Filtered undervoltage: not early, latched after the delay
    wr(`CPF_UV_DELAY, 32'h1);
    cond.cell_undervoltage <= 6'h04;
    repeat (2400) @(posedge aclk);
    pin(1'b0, 1'b0);
    repeat (1400) @(posedge aclk);
    pin(1'b1, 1'b0);
    cond <= '0;
    repeat (20) @(posedge aclk);
    rc(`CPF_UV_FLAGS, 32'h4);
    rc(`CPF_FAULT_STATUS, 32'h2);
    rc(`CPF_DEV_STATUS, 32'h1);
    wr(`CPF_FAULT_STATUS, 32'h2);
    wr(`CPF_FAULT_STATUS, 32'h0);
    rc(`CPF_UV_FLAGS, 32'h0);
    pin(1'b0, 1'b0);
    // Thermal alert, cleared while the cause stays, comes back
    wr(`CPF_OT_DELAY, 32'h1);
    cond.over_temperature <= 2'b01;
    repeat (3800) @(posedge aclk);
    pin(1'b0, 1'b1);
    rc(`CPF_ALERT_STATUS, 32'h1);
    wr(`CPF_ALERT_STATUS, 32'h1);
    pin(1'b0, 1'b0);
    repeat (2000) @(posedge aclk);
    pin(1'b0, 1'b0);
    repeat (1800) @(posedge aclk);
    pin(1'b0, 1'b1);
    cond <= '0;
    repeat (10) @(posedge aclk);
    wr(`CPF_ALERT_STATUS, 32'h1);
    wr(`CPF_ALERT_STATUS, 32'h0);
    pin(1'b0, 1'b0);
    // Fault from the higher device passes down
    hi_fault <= 1'b1;
    repeat (6) @(posedge aclk);
    pin(1'b1, 1'b0);
    hi_fault <= 1'b0;
    repeat (6) @(posedge aclk);
    pin(1'b0, 1'b0);
    // Alert from the higher device passes down
    hi_alert <= 1'b1;
    repeat (6) @(posedge aclk);
    pin(1'b0, 1'b1);
    hi_alert <= 1'b0;
    repeat (6) @(posedge aclk);
    pin(1'b0, 1'b0);
    close_out();
  end
endmodule // test_cell_protection_fault_logic
